/* src/tbh_pkg.sv */
// constants for the toggle-bit telegram handshake block
package tbh_pkg;

    // telegram image geometry
    localparam int IMG_BYTES = 12;
    localparam int IMG_W     = IMG_BYTES * 8;
    localparam int CTRL_BYTE = 0;
    localparam int CMD_BYTE  = 2;
    localparam int PARI_BYTE = 4;
    localparam int DATA_BYTE = 8;

    // control byte bit positions
    localparam int DS_BIT = 2;
    localparam int UM_BIT = 1;
    localparam int US_BIT = 0;

    // reply counter values
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX   = 8'hFF;
    localparam logic [7:0] CNT_WRAP  = 8'h01;

    // apb register byte offsets
    localparam logic [11:0] REG_CTRL     = 12'h000;
    localparam logic [11:0] REG_STATUS   = 12'h004;
    localparam logic [11:0] REG_IRQ_STAT = 12'h008;
    localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
    localparam logic [11:0] REG_CMD      = 12'h010;
    localparam logic [11:0] REG_CMD_PAR  = 12'h014;
    localparam logic [11:0] REG_CMD_DATA = 12'h018;
    localparam logic [11:0] REG_RESP     = 12'h01C;
    localparam logic [11:0] REG_PUSH     = 12'h020;
    localparam logic [11:0] REG_REPLY    = 12'h024;

    // interrupt status bits
    localparam int IRQ_CMD   = 0;
    localparam int IRQ_PURGE = 1;
    localparam int IRQ_SENT  = 2;
    localparam int IRQ_W     = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    // control register bit
    localparam int CTRL_SEND = 0;

    // handshake states
    typedef enum logic [1:0] {
        ST_START = 2'b01,
        ST_RUN   = 2'b10
    } tbh_state_type;

endpackage

/* src/tbh_telegram.sv */
// telegram handshake engine with apb register file and response store
//
// What this block does
// - byte 0 is control: purge bit 2, host-valid 1, device-valid 0, rest 0
// - input image: ctrl, rsvd, echo cmd, rsvd, status, counter, 2 params, data
// - host inverting purge bit discards all stored response data
// - device acknowledges an accepted command with inverted host-valid bit
// - device flags a fresh response by changing its device-valid bit
// - device holds further responses until host acknowledged the last one
// - on purge the device echoes the new purge bit and empties the store
// - at start each side outputs the inverse of the other's valid bit
// - response goes out with device-valid set equal to the host's copy
// - both images are sampled once per process-data cycle
// - reply counter starts at zero, counts content changes, wraps FF to 01
`timescale 1ns/1ps
module tbh_telegram
    import tbh_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             cken,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             pd_cycle,
    input  wire logic [IMG_W-1:0] out_image,
    output logic      [IMG_W-1:0] in_image,
    output logic                  irq
);

    localparam int PW = $clog2(FIFO_DEPTH);

    // parameter check
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128 ||
        (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two from 2 to 128");
    end

    typedef struct packed {
        tbh_state_type                st;
        logic                         prev_um;
        logic                         prev_ds;
        logic                         in_ds;
        logic                         in_um;
        logic                         in_us;
        logic [7:0]                   cmd_code;
        logic [31:0]                  cmd_par;
        logic [31:0]                  cmd_data;
        logic [7:0]                   resp_stat;
        logic [15:0]                  resp_par;
        logic                         send_req;
        logic [7:0]                   img_cmd;
        logic [7:0]                   img_stat;
        logic [7:0]                   img_cnt;
        logic [15:0]                  img_par;
        logic [31:0]                  img_data;
        logic [FIFO_DEPTH-1:0][31:0]  fifo;
        logic [PW-1:0]                rd;
        logic [PW-1:0]                wr;
        logic [PW:0]                  count;
        logic [IRQ_W-1:0]             irq_stat;
        logic [IRQ_W-1:0]             irq_mask;
        logic [31:0]                  prdata;
        logic                         pslverr;
    } tbh_regs_type;

    tbh_regs_type r;
    tbh_regs_type next_r;

    // byte pick from a telegram image
    function automatic logic [7:0] img_byte(input logic [IMG_W-1:0] img,
                                            input int idx);
        return img[idx*8 +: 8];
    endfunction

    // reply counter step, never returns to zero
    function automatic logic [7:0] cnt_step(input logic [7:0] c);
        return (c == CNT_MAX) ? CNT_WRAP : c + 8'h01;
    endfunction

    logic [7:0]  host_ctrl;
    logic        um_o;
    logic        ds_o;
    logic        us_o;
    logic        cyc;
    logic        fifo_full;
    logic        fifo_empty;
    logic        addr_ok;
    logic        wr_acc;
    logic        rd_acc;
    logic        setup;

    // host control byte fields and bus phases
    assign host_ctrl  = img_byte(out_image, CTRL_BYTE);
    assign um_o       = host_ctrl[UM_BIT];
    assign ds_o       = host_ctrl[DS_BIT];
    assign us_o       = host_ctrl[US_BIT];
    assign cyc        = pd_cycle & cken;
    assign fifo_full  = (r.count == (PW+1)'(FIFO_DEPTH));
    assign fifo_empty = (r.count == '0);
    assign setup      = psel & ~penable & cken;
    assign wr_acc     = psel & penable & pwrite & cken;
    assign rd_acc     = psel & penable & ~pwrite & cken;
    assign addr_ok    = (paddr[1:0] == 2'b00) && (paddr <= REG_REPLY);

    // next-state logic
    always_comb begin
        logic do_push;
        logic do_pop;
        logic do_purge;
        logic do_send;
        logic [31:0] send_data;
        logic [IRQ_W-1:0] ev;
        do_push   = 1'b0;
        do_pop    = 1'b0;
        do_purge  = 1'b0;
        do_send   = 1'b0;
        send_data = 32'h0000_0000;
        ev        = '0;
        next_r    = r;

        // read data and error captured in the setup phase
        if (setup) begin
            next_r.pslverr = ~addr_ok |
                             (pwrite && paddr == REG_PUSH && fifo_full);
            next_r.prdata  = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    REG_CTRL:     next_r.prdata[CTRL_SEND] = r.send_req;
                    REG_STATUS:   next_r.prdata = {16'h0000, 8'(r.count),
                                      4'h0, fifo_full, fifo_empty,
                                      (r.st == ST_RUN), r.send_req};
                    REG_IRQ_STAT: next_r.prdata[IRQ_W-1:0] = r.irq_stat;
                    REG_IRQ_MASK: next_r.prdata[IRQ_W-1:0] = r.irq_mask;
                    REG_CMD:      next_r.prdata[7:0] = r.cmd_code;
                    REG_CMD_PAR:  next_r.prdata = r.cmd_par;
                    REG_CMD_DATA: next_r.prdata = r.cmd_data;
                    REG_RESP:     next_r.prdata = {8'h00, r.resp_par,
                                                   r.resp_stat};
                    REG_REPLY:    next_r.prdata[7:0] = r.img_cnt;
                    default:      next_r.prdata = 32'h0000_0000;
                endcase
            end
        end

        // read of interrupt status clears the bits it returned
        if (rd_acc && paddr == REG_IRQ_STAT) begin
            next_r.irq_stat = r.irq_stat & ~r.prdata[IRQ_W-1:0];
        end

        // one sample of the host image per process-data cycle
        if (cyc) begin
            unique case (r.st)
                ST_START: begin
                    // first sample: show ready by inverting host-valid
                    next_r.in_um   = ~um_o;
                    next_r.in_ds   = ds_o;
                    next_r.prev_um = um_o;
                    next_r.prev_ds = ds_o;
                    next_r.st      = ST_RUN;
                end
                ST_RUN: begin
                    next_r.prev_um = um_o;
                    next_r.prev_ds = ds_o;
                    // purge toggle compared with previous sample
                    if (ds_o != r.prev_ds) begin
                        do_purge     = 1'b1;
                        next_r.in_ds = ds_o;
                        ev[IRQ_PURGE] = 1'b1;
                    end
                    // fresh command from the host
                    if (um_o != r.prev_um) begin
                        next_r.cmd_code = img_byte(out_image, CMD_BYTE);
                        next_r.cmd_par  = out_image[PARI_BYTE*8 +: 32];
                        next_r.cmd_data = out_image[DATA_BYTE*8 +: 32];
                        next_r.in_um    = ~um_o;
                        ev[IRQ_CMD]     = 1'b1;
                    end
                    // send only once the host has returned the inverse
                    if (r.send_req && (us_o != r.in_us)) begin
                        do_send = 1'b1;
                    end
                end
                default: next_r.st = ST_START;
            endcase
        end

        // response publication
        if (do_send) begin
            if (!fifo_empty && !do_purge) begin
                send_data = r.fifo[r.rd];
                do_pop    = 1'b1;
            end
            next_r.img_cmd  = r.cmd_code;
            next_r.img_stat = r.resp_stat;
            next_r.img_par  = r.resp_par;
            next_r.img_data = send_data;
            // count only when the response field really changes
            if ({r.cmd_code, r.resp_stat, r.resp_par, send_data} !=
                {r.img_cmd, r.img_stat, r.img_par, r.img_data}) begin
                next_r.img_cnt = cnt_step(r.img_cnt);
            end
            next_r.in_us    = us_o;
            next_r.send_req = 1'b0;
            ev[IRQ_SENT]    = 1'b1;
        end

        // register writes in the access phase
        if (wr_acc) begin
            unique case (paddr)
                REG_CTRL: begin
                    if (pwdata[CTRL_SEND]) begin
                        next_r.send_req = 1'b1;
                    end
                end
                REG_IRQ_MASK: next_r.irq_mask = pwdata[IRQ_W-1:0];
                REG_RESP: begin
                    next_r.resp_stat = pwdata[7:0];
                    next_r.resp_par  = pwdata[23:8];
                end
                REG_PUSH: do_push = ~fifo_full;
                default: ;
            endcase
        end

        // response store update, purge drops everything
        if (do_purge) begin
            next_r.rd    = '0;
            next_r.wr    = '0;
            next_r.count = '0;
        end else begin
            if (do_push) begin
                next_r.fifo[r.wr] = pwdata;
                next_r.wr         = r.wr + PW'(1);
            end
            if (do_pop) begin
                next_r.rd = r.rd + PW'(1);
            end
            next_r.count = r.count + (PW+1)'(do_push) - (PW+1)'(do_pop);
        end

        // event sets win over the read clear
        next_r.irq_stat = next_r.irq_stat | ev;

        // clock enable low freezes everything
        if (!cken) begin
            next_r = r;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r           <= '0;
            r.st        <= ST_START;
            r.img_cnt   <= CNT_RESET;
            r.irq_mask  <= IRQ_MASK_RESET;
        end else begin
            r <= next_r;
        end
    end

    // outputs: input image built from flops, control bits 7..3 zero
    assign in_image = {r.img_data, r.img_par, r.img_cnt, r.img_stat, 8'h00,
                       r.img_cmd, 8'h00,
                       5'b00000, r.in_ds, r.in_um, r.in_us};
    assign prdata   = r.prdata;
    assign pslverr  = r.pslverr;
    assign pready   = cken;
    assign irq      = |(r.irq_stat & r.irq_mask);

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_running_cycle;
        cyc && (r.st == ST_RUN);
    endsequence

    sequence s_host_toggle;
        s_running_cycle ##0 (um_o != r.prev_um);
    endsequence

    sequence s_purge_toggle;
        s_running_cycle ##0 (ds_o != r.prev_ds);
    endsequence

    property p_ctrl_zero;
        in_image[7:3] == 5'b00000;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("control byte upper bits not zero");

    property p_reserved;
        img_byte(in_image, 1) == 8'h00 && img_byte(in_image, 3) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved byte of input telegram not zero");

    property p_purge_empty;
        s_purge_toggle |=> (r.count == '0) && fifo_empty;
    endproperty
    a_purge_empty: assert property (p_purge_empty)
        else $error("store not empty after purge");

    property p_purge_echo;
        s_purge_toggle |=> in_image[DS_BIT] == $past(ds_o);
    endproperty
    a_purge_echo: assert property (p_purge_echo)
        else $error("purge bit not echoed");

    property p_ack;
        s_host_toggle |=> in_image[UM_BIT] == ~$past(um_o);
    endproperty
    a_ack: assert property (p_ack)
        else $error("command not acknowledged with inverted bit");

    property p_withhold;
        $changed(in_image[US_BIT]) |->
            $past(us_o) != $past(r.in_us) && $past(cyc);
    endproperty
    a_withhold: assert property (p_withhold)
        else $error("response sent before host acknowledge");

    property p_mirror;
        $changed(in_image[US_BIT]) |-> in_image[US_BIT] == $past(us_o);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("device-valid bit not set to host copy");

    property p_start;
        cyc && (r.st == ST_START) |=>
            in_image[UM_BIT] == ~$past(um_o) && r.st == ST_RUN;
    endproperty
    a_start: assert property (p_start)
        else $error("start-up ready state wrong");

    property p_once_per_cycle;
        !cyc |=> $stable(in_image);
    endproperty
    a_once_per_cycle: assert property (p_once_per_cycle)
        else $error("input image changed outside a cycle");

    property p_cnt_nonzero;
        $changed(r.img_cnt) |->
            r.img_cnt != 8'h00 &&
            (($past(r.img_cnt) == CNT_MAX) ? r.img_cnt == CNT_WRAP
                : r.img_cnt == $past(r.img_cnt) + 8'h01);
    endproperty
    a_cnt_nonzero: assert property (p_cnt_nonzero)
        else $error("reply counter stepped wrongly");

endmodule // tbh_telegram

/* verif/tbh_host.sv */
// host controller model driving the output telegram image
`timescale 1ns/1ps
module tbh_host
    import tbh_pkg::*;
#(
    parameter int PD_GAP = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [IMG_W-1:0] in_image,
    output logic                  pd_cycle,
    output logic      [IMG_W-1:0] out_image
);
    logic             hold_ack = 1'b0;
    logic             cmd_pend = 1'b0;
    logic             purge_pend = 1'b0;
    logic [IMG_W-1:0] cmd_frame = '0;
    logic             dev_ready;
    int               cnt;

    // requests from the bench, taken at the next image update
    task automatic send_cmd(input logic [IMG_W-1:0] f);
        cmd_frame <= f;
        cmd_pend  <= 1'b1;
    endtask
    task automatic purge();
        purge_pend <= 1'b1;
    endtask
    task automatic set_hold(input logic h);
        hold_ack <= h;
    endtask

    // device has acknowledged the last command
    assign dev_ready = out_image[UM_BIT] != in_image[UM_BIT];

    // image update two cycles ahead of each process-data pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt       <= 0;
            pd_cycle  <= 1'b0;
            out_image <= '0; // control bits 7..3 stay zero
        end else begin
            cnt      <= (cnt == PD_GAP - 1) ? 0 : cnt + 1;
            pd_cycle <= (cnt == PD_GAP - 1); // one exchange per cycle
            if (cnt == PD_GAP - 3) begin
                // a slow host keeps its response ack back
                if (!hold_ack)
                    out_image[US_BIT] <= ~in_image[US_BIT];
                if (purge_pend) begin
                    out_image[DS_BIT] <= ~out_image[DS_BIT];
                    purge_pend        <= 1'b0;
                end
                if (cmd_pend && dev_ready) begin
                    out_image[IMG_W-1:8] <= cmd_frame[IMG_W-1:8];
                    out_image[UM_BIT]    <= in_image[UM_BIT];
                    cmd_pend             <= 1'b0;
                end
            end
        end
    end
endmodule // tbh_host

/* verif/tbh_telegram_bench.sv */
// self-checking bench for the telegram handshake engine
`timescale 1ns/1ps
module tbh_telegram_bench
    import tbh_pkg::*;
;
    localparam int DEPTH = 4;
    localparam int GAP   = 8;

    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             cken = 1'b1;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [11:0]      paddr = '0;
    logic [31:0]      pwdata = '0;
    logic [31:0]      prdata;
    logic             pready, pslverr, irq, pd_cycle;
    logic [IMG_W-1:0] out_image, in_image;
    logic [31:0]      rd_v;
    logic             err_v;
    logic [31:0]      rnd = 32'h4F832C6B;
    logic [31:0]      fifo[$];
    logic [63:0]      last_cont = '0;
    logic [7:0]       cmd_exp = '0;
    int               reply_cnt = 0;
    int               failures = 0;
    int               num_checks = 0;
    int               i;

    // 20 MHz clock
    always #25 pclk = ~pclk;

    tbh_telegram #(.FIFO_DEPTH(DEPTH)) tbh_telegram_i (
        .pclk(pclk), .presetn(presetn), .cken(cken), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pd_cycle(pd_cycle), .out_image(out_image),
        .in_image(in_image), .irq(irq));

    tbh_host #(.PD_GAP(GAP)) tbh_host_i (
        .pclk(pclk), .presetn(presetn), .in_image(in_image),
        .pd_cycle(pd_cycle), .out_image(out_image));

    function automatic logic [31:0] next_rand();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd;
    endfunction

    task automatic check(input logic [IMG_W-1:0] got,
                         input logic [IMG_W-1:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask

    // one apb transfer, held until pready at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            failures++;
            $display("CHECK FAILED at %0t: bus timeout", $time);
        end
        rd_v = prdata;
        err_v = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic irq_chk(input logic [2:0] bits);
        repeat (2) @(posedge pclk);
        check(irq, 1'b1, "irq raised");
        apb(1'b0, REG_IRQ_STAT, 32'h0);
        check(rd_v, bits, "irq status");
        repeat (2) @(posedge pclk);
        check(irq, 1'b0, "irq cleared");
    endtask

    task automatic push(input logic [31:0] w);
        logic full;
        full = (fifo.size() == DEPTH);
        apb(1'b1, REG_PUSH, w);
        check(err_v, full, "push refusal");
        if (!full)
            fifo.push_back(w);
    endtask

    task automatic do_cmd();
        logic [IMG_W-1:0] f;
        int               n;
        f = {next_rand(), next_rand(), next_rand() & 32'h00FF0000};
        cmd_exp = f[23:16];
        tbh_host_i.send_cmd(f);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100) begin
            failures++;
            $display("CHECK FAILED at %0t: command timeout", $time);
        end
        irq_chk(3'h1);
        check(in_image[UM_BIT], {~out_image[UM_BIT]}, "cmd ack");
        apb(1'b0, REG_CMD, 32'h0);
        check(rd_v, {24'h0, cmd_exp}, "cmd code");
        apb(1'b0, REG_CMD_PAR, 32'h0);
        check(rd_v, f[63:32], "cmd params");
        apb(1'b0, REG_CMD_DATA, 32'h0);
        check(rd_v, f[95:64], "cmd data");
    endtask

    // one response; with hold the host acks late
    task automatic do_send(input logic hold);
        logic [31:0] resp, w;
        logic        us0;
        int          n;
        resp = next_rand();
        apb(1'b1, REG_RESP, resp);
        apb(1'b1, REG_CTRL, 32'h1);
        us0 = in_image[US_BIT];
        if (hold) begin
            repeat (3 * GAP) @(posedge pclk);
            check(in_image[US_BIT], us0, "response withheld");
            apb(1'b0, REG_CTRL, 32'h0);
            check(rd_v, 32'h0000_0001, "send still pending");
            tbh_host_i.set_hold(1'b0);
        end
        n = 0;
        while (in_image[US_BIT] === us0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200) begin
            failures++;
            $display("CHECK FAILED at %0t: response timeout", $time);
        end
        w = (fifo.size() > 0) ? fifo.pop_front() : 32'h0;
        if ({w, resp[23:0], cmd_exp} !== last_cont) begin
            reply_cnt = (reply_cnt == 255) ? 1 : reply_cnt + 1;
            last_cont = {w, resp[23:0], cmd_exp};
        end
        check(in_image, {w, resp[23:8], reply_cnt[7:0], resp[7:0], 8'h00,
              cmd_exp, 8'h00, 5'h00, out_image[DS_BIT], ~out_image[UM_BIT],
              ~us0}, "response image");
        irq_chk(3'h4);
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge pclk);
        check(in_image, '0, "reset image");
        presetn <= 1'b1;
        apb(1'b0, REG_IRQ_MASK, 32'h0);
        check(rd_v, 32'h0, "mask reset");
        apb(1'b0, 12'h028, 32'h0);
        check({err_v, rd_v}, 33'h100000000, "unmapped read");
        apb(1'b1, REG_IRQ_MASK, 32'h7);
        repeat (2 * GAP) @(posedge pclk);
        check({in_image[UM_BIT], in_image[DS_BIT]},
              {~out_image[UM_BIT], out_image[DS_BIT]}, "start-up");
        $display("test reset done");
        do_cmd();
        do_send(1'b0);
        $display("test command done");
        push(next_rand());
        push(next_rand());
        tbh_host_i.set_hold(1'b1);
        do_send(1'b0);
        do_send(1'b1);
        $display("test slow host done");
        push(next_rand());
        push(next_rand());
        tbh_host_i.purge();
        // clock enable low: the purge toggle must wait for the thaw
        cken <= 1'b0;
        repeat (2 * GAP) @(posedge pclk);
        check({irq, in_image[DS_BIT]}, 2'b00, "frozen image");
        cken <= 1'b1;
        i = 0;
        while (in_image[DS_BIT] === 1'b0 && i < 100) begin
            @(posedge pclk);
            i++;
        end
        if (i >= 100) begin
            failures++;
            $display("CHECK FAILED at %0t: purge timeout", $time);
        end
        irq_chk(3'h2);
        fifo.delete();
        apb(1'b0, REG_STATUS, 32'h0);
        check(rd_v, 32'h00000006, "store empty after purge");
        do_send(1'b0);
        $display("test purge done");
        for (i = 0; i < DEPTH + 1; i++)
            push(next_rand());
        apb(1'b0, REG_STATUS, 32'h0);
        check(rd_v, 32'h0000040A, "store full");
        do_cmd();
        for (i = 0; i < 262; i++)
            do_send(1'b0);
        apb(1'b0, REG_REPLY, 32'h0);
        check(rd_v, {24'h0, reply_cnt[7:0]}, "reply register");
        $display("test counter wrap done");
        stop_test();
    end

    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        stop_test();
    end
endmodule // tbh_telegram_bench
